// File: core/scale_weight_filter_peak_hold.sv
// Scale weight processing: three averaging stages with cutout,
// vibration cancelling, tare gating, accumulate, visibility, peak hold.
// Assumes readings, keys and settings are synchronous to sys_clk.
`timescale 1ns/1ns
`default_nettype none
`include "scale_filter_params.svh"

module scale_weight_filter_peak_hold #(
  parameter int W = 24,
  parameter int ACC_W = 32,
  parameter int VIB_PERIOD = `VIB_PERIOD
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reading_valid,
  input wire logic signed [W-1:0] reading,
  input wire logic cfg_load,
  input wire logic [3:0] avg_stage_one,
  input wire logic [3:0] avg_stage_two,
  input wire logic [3:0] avg_stage_three,
  input wire logic [2:0] outlier_run_length,
  input wire logic [3:0] cutout_band,
  input wire logic vibration_cancel,
  input wire scale_filter_pkg::tare_perm_type tare_permission,
  input wire logic accumulate_on_print,
  input wire logic scale_visible,
  input wire scale_filter_pkg::peak_mode_type peak_mode,
  input wire logic [15:0] division_size,
  input wire logic standstill,
  input wire logic pushbutton_tare,
  input wire logic keyed_tare,
  input wire logic signed [W-1:0] keyed_tare_value,
  input wire logic zero_key,
  input wire logic print_key,
  input wire logic print_done,
  output logic signed [W-1:0] gross_q,
  output logic signed [W-1:0] net_q,
  output logic signed [W-1:0] tare_q,
  output logic tare_refused_q,
  output logic signed [W-1:0] peak_q,
  output logic print_req_q,
  output logic signed [ACC_W-1:0] accumulate_on_print_q,
  output logic signed [W-1:0] display_q,
  output logic display_on_q,
  output logic cutout_q
);
  import scale_filter_pkg::*;

  // Magnitude of a signed difference
  function automatic logic [W:0] mag(input logic signed [W:0] v);
    mag = v[W] ? -v : v;
  endfunction : mag

  // Band width in display divisions for a band code
  function automatic logic [7:0] band_divs(input logic [3:0] code);
    unique case (code)
      4'h1: band_divs = `BAND_C1;
      4'h2: band_divs = `BAND_C2;
      4'h3: band_divs = `BAND_C3;
      4'h4: band_divs = `BAND_C4;
      4'h5: band_divs = `BAND_C5;
      4'h6: band_divs = `BAND_C6;
      4'h7: band_divs = `BAND_C7;
      4'h8: band_divs = `BAND_C8;
      default: band_divs = `BAND_NONE;
    endcase
  endfunction : band_divs

  // Clamp a stage code onto the legal lengths
  function automatic logic [3:0] avg_code(input logic [3:0] c);
    avg_code = (c > `AVG_CODE_MAX) ? `AVG_CODE_MAX : c;
  endfunction : avg_code

  // Captured settings
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [2:0] run_q;
  logic [3:0] band_q;
  logic vib_q;
  tare_perm_type perm_q;
  logic acc_en_q;
  logic vis_q;
  peak_mode_type mode_q;

  // Filter feed, cutout and peak sequence state
  logic feed_valid_q;
  logic feed_reload_q;
  logic signed [W-1:0] feed_data_q;
  logic reconf_q;
  logic [7:0] out_cnt_q;
  logic seen_q;
  peak_state_type pk_q;
  peak_state_type pk_d;

  sample_if #(.W(W)) l0 ();
  sample_if #(.W(W)) l1 ();
  sample_if #(.W(W)) l2 ();
  sample_if #(.W(W)) l3 ();
  sample_if #(.W(W)) l4 ();

  assign l0.valid = feed_valid_q;
  assign l0.reload = feed_reload_q;
  assign l0.data = feed_data_q;

  // Three cascaded stages, then the canceller
  avg_stage #(.W(W)) stage_a (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .shift(s1_q),
    .in_link(l0.rx),
    .out_link(l1.tx)
  );
  avg_stage #(.W(W)) stage_b (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .shift(s2_q),
    .in_link(l1.rx),
    .out_link(l2.tx)
  );
  avg_stage #(.W(W)) stage_c (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .shift(s3_q),
    .in_link(l2.rx),
    .out_link(l3.tx)
  );
  vibration_comb #(.W(W), .PERIOD(VIB_PERIOD)) canceller (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .enable(vib_q),
    .in_link(l3.rx),
    .out_link(l4.tx)
  );

  // Cutout decode: reading against the filtered weight
  wire logic [7:0] divs_w = band_divs(band_q);
  wire logic [W:0] band_w = (W+1)'(divs_w) * (W+1)'(division_size);
  wire logic [W:0] dev_w = mag((W+1)'(reading) - (W+1)'(gross_q));
  wire logic outside_w = (divs_w != `BAND_NONE) && (dev_w > band_w);
  wire logic [7:0] run_w = `RUN_BASE << run_q;
  wire logic [7:0] cnt_inc_w = out_cnt_q + 8'h01;
  wire logic hit_w = reading_valid && outside_w && (cnt_inc_w >= run_w);

  // Settings capture with their reset defaults
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q <= `AVG_CODE_RST;
      s2_q <= `AVG_CODE_RST;
      s3_q <= `AVG_CODE_RST;
      run_q <= `RUN_CODE_RST;
      band_q <= `BAND_CODE_RST;
      vib_q <= `VIB_RST;
      perm_q <= tare_both;
      acc_en_q <= `ACCUMULATE_ON_PRINT_RST;
      vis_q <= `VISIBLE_RST;
      mode_q <= peak_off;
    end
    else if (cfg_load)
    begin
      s1_q <= avg_code(avg_stage_one);
      s2_q <= avg_code(avg_stage_two);
      s3_q <= avg_code(avg_stage_three);
      run_q <= (outlier_run_length > `RUN_CODE_MAX) ?
               `RUN_CODE_MAX : outlier_run_length;
      band_q <= cutout_band;
      vib_q <= vibration_cancel;
      perm_q <= tare_permission;
      acc_en_q <= accumulate_on_print;
      vis_q <= scale_visible;
      mode_q <= peak_mode;
    end
  end

  // Outlier run counting and filter feed; a new setting restarts
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      feed_valid_q <= 1'b0;
      feed_reload_q <= 1'b0;
      feed_data_q <= '0;
      reconf_q <= 1'b1;
      out_cnt_q <= 8'h00;
      cutout_q <= 1'b0;
    end
    else
    begin
      feed_valid_q <= reading_valid;
      feed_reload_q <= reading_valid && (hit_w || reconf_q);
      cutout_q <= hit_w;
      reconf_q <= cfg_load || (reconf_q && !reading_valid);
      if (reading_valid)
      begin
        feed_data_q <= reading;
        if (hit_w || !outside_w)
          out_cnt_q <= 8'h00;
        else
          out_cnt_q <= cnt_inc_w;
      end
    end
  end

  // Tare gating by permission
  wire logic pb_ok_w = (perm_q == tare_both) ||
                       (perm_q == pushbutton_tare_only);
  wire logic key_ok_w = (perm_q == tare_both) ||
                        (perm_q == keyed_tare_only);

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tare_q <= '0;
      tare_refused_q <= 1'b0;
    end
    else
    begin
      tare_refused_q <= (pushbutton_tare && !pb_ok_w) ||
                        (keyed_tare && !key_ok_w);
      if (keyed_tare && key_ok_w)
        tare_q <= keyed_tare_value;
      else if (pushbutton_tare && pb_ok_w)
        tare_q <= gross_q;
    end
  end

  // Gross and net follow the filtered stream
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gross_q <= '0;
      net_q <= '0;
    end
    else
    begin
      if (l4.valid)
        gross_q <= l4.data;
      net_q <= gross_q - tare_q;
    end
  end

  // Peak candidate and zero window decode
  wire logic [W:0] zero_w = (W+1)'(`PEAK_ZERO_DIVS) * (W+1)'(division_size);
  wire logic [W:0] net_mag_w = mag((W+1)'(net_q));
  wire logic [W:0] peak_mag_w = mag((W+1)'(peak_q));
  wire logic near_zero_w = (net_mag_w <= zero_w);
  wire logic bigger_w = (mode_q == absolute_peak) ?
                        (net_mag_w > peak_mag_w) :
                        (net_q > peak_q);
  wire logic manual_w = (mode_q == peak_normal) ||
                        (mode_q == absolute_peak);
  wire logic key_clr_w = manual_w && (zero_key || print_key) &&
                         near_zero_w;
  wire logic auto_go_w = (mode_q == peak_auto) && seen_q &&
                         near_zero_w && standstill;
  wire logic auto_done_w = (pk_q == pk_print) && print_done;

  // Auto peak sequence
  always_comb
  begin
    pk_d = pk_q;
    unique case (pk_q)
      pk_track: if (auto_go_w) pk_d = pk_print;
      pk_print: if (print_done) pk_d = pk_clear;
      pk_clear: pk_d = pk_track;
      default: pk_d = pk_track;
    endcase
  end

  // Peak register: track, then clear at the end of the cycle
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pk_q <= pk_track;
      peak_q <= '0;
      seen_q <= 1'b0;
      print_req_q <= 1'b0;
    end
    else
    begin
      pk_q <= pk_d;
      print_req_q <= (pk_d == pk_print);
      if (mode_q == peak_off || key_clr_w || pk_q == pk_clear)
      begin
        peak_q <= '0;
        seen_q <= 1'b0;
      end
      else if (pk_q == pk_track)
      begin
        if (bigger_w && (manual_w || net_q > peak_q))
          peak_q <= net_q;
        if (mode_q == peak_auto && !near_zero_w && net_q > peak_q)
          seen_q <= 1'b1;
      end
    end
  end

  // Accumulator: add on every print while enabled
  wire logic signed [W-1:0] acc_src_w = auto_done_w ? peak_q : net_q;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      accumulate_on_print_q <= '0;
    else if (acc_en_q && (print_key || auto_done_w))
      accumulate_on_print_q <= accumulate_on_print_q + ACC_W'(acc_src_w);
  end

  // Display selection, blanked while the scale is hidden
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      display_q <= '0;
      display_on_q <= `VISIBLE_RST;
    end
    else
    begin
      display_on_q <= vis_q;
      if (!vis_q)
        display_q <= '0;
      else if (mode_q != peak_off)
        display_q <= peak_q;
      else
        display_q <= net_q;
    end
  end

endmodule : scale_weight_filter_peak_hold

`default_nettype wire

// File: core/scale_filter_params.svh
// Numeric constants of the scale weight filter: reset values,
// setting codes and band figures.
// Assumes inclusion by bare name wherever a figure is needed.
`ifndef SCALE_FILTER_PARAMS_SVH
`define SCALE_FILTER_PARAMS_SVH

// Stage length codes: length = 1 << code, code 0..8 (1..256)
`define AVG_CODE_MAX 4'h8
`define AVG_CODE_RST 4'h2
// Outlier run codes: run = 2 << code, code 0..6 (2..128)
`define RUN_CODE_MAX 3'h6
`define RUN_CODE_RST 3'h0
`define RUN_BASE 8'h02
// Cutout band codes, code 0 is none
`define BAND_CODE_RST 4'h0
`define BAND_NONE 8'h00
`define BAND_C1 8'h02
`define BAND_C2 8'h05
`define BAND_C3 8'h0a
`define BAND_C4 8'h14
`define BAND_C5 8'h32
`define BAND_C6 8'h64
`define BAND_C7 8'hc8
`define BAND_C8 8'hfa
// Auto print window around zero, in display divisions
`define PEAK_ZERO_DIVS 8'h0a
// Reset values of the loose setting bits
`define ACCUMULATE_ON_PRINT_RST 1'b0
`define VISIBLE_RST 1'b1
`define VIB_RST 1'b0
// Default cancel period in readings
`define VIB_PERIOD 16

`endif

// File: core/scale_filter_pkg.sv
// Types shared by the scale weight filter modules.
// Assumes no other package.
package scale_filter_pkg;

  typedef enum logic [1:0] {
    tare_both = 2'b00,
    tare_forbidden = 2'b01,
    pushbutton_tare_only = 2'b10,
    keyed_tare_only = 2'b11
  } tare_perm_type;

  typedef enum logic [1:0] {
    peak_off = 2'b00,
    peak_normal = 2'b01,
    absolute_peak = 2'b10,
    peak_auto = 2'b11
  } peak_mode_type;

  typedef enum logic [1:0] {
    pk_track = 2'b00,
    pk_print = 2'b01,
    pk_clear = 2'b11
  } peak_state_type;

endpackage : scale_filter_pkg

// File: core/sample_if.sv
// Sample link between filter sections: one reading per valid pulse,
// with a reload flag that restarts the receiving history.
// Assumes both ends share sys_clk.
`timescale 1ns/1ns
`default_nettype none

interface sample_if #(parameter int W = 24);
  logic valid;
  logic reload;
  logic signed [W-1:0] data;
  modport tx (output valid, output reload, output data);
  modport rx (input valid, input reload, input data);
endinterface : sample_if

`default_nettype wire

// File: core/avg_stage.sv
// One rolling-average stage of length 1 << shift (1..256).
// Assumes a reload accompanies any change of shift.
`timescale 1ns/1ns
`default_nettype none

module avg_stage #(
  parameter int W = 24,
  parameter int DEPTH = 256
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] shift,
  sample_if.rx in_link,
  sample_if.tx out_link
);
  import scale_filter_pkg::*;

  localparam int SW = W + 9;

  logic signed [W-1:0] mem [0:DEPTH-1];
  logic [DEPTH-1:0] vld_q;
  logic [7:0] idx_q;
  logic signed [W-1:0] fill_q;
  logic signed [SW-1:0] sum_q;
  logic valid_q;
  logic reload_q;
  logic signed [W-1:0] data_q;

  // Stale slots read as the reload value
  wire logic signed [W-1:0] old_w = vld_q[idx_q] ? mem[idx_q] : fill_q;
  wire logic [7:0] mask_w = 8'((9'h001 << shift) - 9'h001);
  wire logic [7:0] nidx_w = (idx_q + 8'h01) & mask_w;
  wire logic signed [SW-1:0] sum_d = sum_q - SW'(old_w) + SW'(in_link.data);
  wire logic signed [SW-1:0] seed_w = SW'(in_link.data) <<< shift;
  wire logic signed [SW-1:0] avg_w = sum_d >>> shift;

  // History storage, no reset needed behind the valid bits
  always_ff @(posedge sys_clk)
  begin
    if (in_link.valid && !in_link.reload)
      mem[idx_q] <= in_link.data;
  end

  // Running sum and output; reload restarts the history
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vld_q <= '0;
      idx_q <= 8'h00;
      fill_q <= '0;
      sum_q <= '0;
      valid_q <= 1'b0;
      reload_q <= 1'b0;
      data_q <= '0;
    end
    else
    begin
      valid_q <= in_link.valid;
      reload_q <= in_link.valid && in_link.reload;
      if (in_link.valid && in_link.reload)
      begin
        vld_q <= '0;
        idx_q <= 8'h00;
        fill_q <= in_link.data;
        sum_q <= seed_w;
        data_q <= in_link.data;
      end
      else if (in_link.valid)
      begin
        vld_q[idx_q] <= 1'b1;
        idx_q <= nidx_w;
        sum_q <= sum_d;
        data_q <= W'(avg_w);
      end
    end
  end

  assign out_link.valid = valid_q;
  assign out_link.reload = reload_q;
  assign out_link.data = data_q;

endmodule : avg_stage

`default_nettype wire

// File: core/vibration_comb.sv
// Repeating-vibration canceller: averages each reading with the one
// a full period back, nulling the odd harmonics of twice that period.
// Assumes the filtered link feeds it; reload restarts its history.
`timescale 1ns/1ns
`default_nettype none
`include "scale_filter_params.svh"

module vibration_comb #(
  parameter int W = 24,
  parameter int PERIOD = `VIB_PERIOD
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic enable,
  sample_if.rx in_link,
  sample_if.tx out_link
);
  import scale_filter_pkg::*;

  localparam int AW = $clog2(PERIOD);

  logic signed [W-1:0] mem [0:PERIOD-1];
  logic [PERIOD-1:0] vld_q;
  logic [AW-1:0] idx_q;
  logic signed [W-1:0] fill_q;
  logic valid_q;
  logic reload_q;
  logic signed [W-1:0] data_q;

  wire logic signed [W-1:0] old_w = vld_q[idx_q] ? mem[idx_q] : fill_q;
  wire logic signed [W:0] pair_w = (W+1)'(old_w) + (W+1)'(in_link.data);
  wire logic last_w = (idx_q == AW'(PERIOD - 1));

  // Delay line storage
  always_ff @(posedge sys_clk)
  begin
    if (in_link.valid)
      mem[idx_q] <= in_link.data;
  end

  // Cancelled output, slower to settle than plain averaging
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vld_q <= '0;
      idx_q <= '0;
      fill_q <= '0;
      valid_q <= 1'b0;
      reload_q <= 1'b0;
      data_q <= '0;
    end
    else
    begin
      valid_q <= in_link.valid;
      reload_q <= in_link.valid && in_link.reload;
      if (in_link.valid)
      begin
        idx_q <= last_w ? '0 : idx_q + AW'(1);
        if (in_link.reload)
        begin
          vld_q <= '0;
          fill_q <= in_link.data;
          data_q <= in_link.data;
        end
        else
        begin
          vld_q[idx_q] <= 1'b1;
          data_q <= enable ? W'(pair_w >>> 1) : in_link.data;
        end
      end
    end
  end

  assign out_link.valid = valid_q;
  assign out_link.reload = reload_q;
  assign out_link.data = data_q;

endmodule : vibration_comb

`default_nettype wire

// File: tb/adc_model.sv
// Converter stand-in: one reading pulse per request, after dly cycles.
// Assumes the bench raises go for one cycle, shortly after an edge.
`timescale 1ns/1ns
`default_nettype none

module adc_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic [3:0] dly,
  input wire logic signed [23:0] value,
  output logic reading_valid,
  output logic signed [23:0] reading
);
  logic [3:0] cnt_q;
  logic signed [23:0] hold_q;
  logic fire;
  logic signed [23:0] data;

  // Fire now or when the delay count expires
  assign fire = go ? (dly == 4'h0) : (cnt_q == 4'h1);
  assign data = go ? value : hold_q;

  // Between pulses the data lines show the inverse of the last requested value
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q <= 4'h0;
      hold_q <= 24'h00_0000;
      reading_valid <= 1'b0;
      reading <= 24'h00_0000;
    end
    else
    begin
      cnt_q <= go ? dly : (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
      hold_q <= data;
      reading_valid <= fire;
      reading <= fire ? data : ~data;
    end
  end
endmodule : adc_model

`default_nettype wire

// File: tb/scale_weight_filter_peak_hold_props.sv
// Port checker for the scale weight filter, bound to the top module.
// Assumes one clock, sys_clk, and asynchronous active-high sys_rst.
`timescale 1ns/1ns
`default_nettype none

module scale_weight_filter_peak_hold_props #(
  parameter int W = 24,
  parameter int ACC_W = 32
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reading_valid,
  input wire logic signed [W-1:0] reading,
  input wire logic [15:0] division_size,
  input wire logic pushbutton_tare,
  input wire logic keyed_tare,
  input wire logic signed [W-1:0] keyed_tare_value,
  input wire logic zero_key,
  input wire logic print_key,
  input wire logic print_done,
  input wire logic signed [W-1:0] gross_q,
  input wire logic signed [W-1:0] net_q,
  input wire logic signed [W-1:0] tare_q,
  input wire logic tare_refused_q,
  input wire logic signed [W-1:0] peak_q,
  input wire logic print_req_q,
  input wire logic signed [ACC_W-1:0] accumulate_on_print_q,
  input wire logic signed [W-1:0] display_q,
  input wire logic display_on_q,
  input wire logic cutout_q
);
  logic [W-1:0] mag;
  logic [19:0] lim;
  logic signed [W-1:0] rp_q, cv_q, kv_q;

  // Net magnitude against the ten-division zero window
  assign mag = net_q[W-1] ? W'(-net_q) : W'(net_q);
  assign lim = 20'(division_size) * 20'h0_000a;

  // Last reading, reading behind a cutout, last keyed tare value
  always_ff @(posedge sys_clk)
  begin
    rp_q <= reading;
    cv_q <= cutout_q ? rp_q : cv_q;
    kv_q <= keyed_tare ? keyed_tare_value : kv_q;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  a_keyed_tare_taken:
    assert property (keyed_tare && !pushbutton_tare |-> ##[1:2]
      (tare_refused_q || tare_q == kv_q)) else $error("keyed tare lost");
  a_refused_tare_kept:
    assert property (tare_refused_q && !$past(keyed_tare && pushbutton_tare)
      |-> $stable(tare_q))
    else $error("refused tare changed tare");
  a_net_from_tare:
    assert property (net_q == W'($past(gross_q) - $past(tare_q)))
    else $error("net is not gross minus tare");
  a_cutout_jumps:
    assert property (cutout_q |-> ##[3:6] gross_q == cv_q)
    else $error("gross did not jump to cutout reading");
  a_cutout_single:
    assert property (cutout_q |-> ($past(reading_valid) ||
      $past(reading_valid, 2)) ##1 !cutout_q)
    else $error("cutout without reading or repeated");
  a_print_req_holds:
    assert property (print_req_q && !print_done |=> print_req_q)
    else $error("print request dropped early");
  a_auto_peak_clear:
    assert property (print_req_q && print_done |-> ##[1:4] peak_q == '0)
    else $error("peak not cleared after print");
  a_zero_key_clear:
    assert property (zero_key && mag <= lim |-> ##[1:2] peak_q == '0)
    else $error("zero key did not clear peak");
  a_hidden_blank:
    assert property (!display_on_q [*3] |-> display_q == '0)
    else $error("hidden scale shows data");
  a_accumulate_on_print_idle:
    assert property (!print_key && !print_done && !$past(print_key) &&
      !$past(print_done) |=> $stable(accumulate_on_print_q))
    else $error("accumulator moved without print");

  // Main scenarios reached
  c_cutout: cover property (cutout_q);
  c_print: cover property ($rose(print_req_q));
  c_refused: cover property (tare_refused_q);
endmodule : scale_weight_filter_peak_hold_props

bind scale_weight_filter_peak_hold scale_weight_filter_peak_hold_props
  #(.W(W), .ACC_W(ACC_W)) props_inst (.sys_clk, .sys_rst, .reading_valid,
  .reading, .division_size, .pushbutton_tare, .keyed_tare,
  .keyed_tare_value, .zero_key, .print_key, .print_done, .gross_q, .net_q,
  .tare_q, .tare_refused_q, .peak_q, .print_req_q, .accumulate_on_print_q, .display_q,
  .display_on_q, .cutout_q);

`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the scale weight filter with peak hold.
// Assumes the converter model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import scale_filter_pkg::*;
  logic sys_clk = 0, sys_rst = 1, reading_valid, cfg_load = 0, go = 0;
  logic signed [23:0] reading, value = 0, keyed_tare_value = 0;
  logic [3:0] avg_stage_one = 2, avg_stage_two = 2, avg_stage_three = 2;
  logic [3:0] cutout_band = 0, dly = 0;
  logic [2:0] outlier_run_length = 0;
  logic vibration_cancel = 0, accumulate_on_print = 0, scale_visible = 1;
  logic standstill = 0, pushbutton_tare = 0, keyed_tare = 0, zero_key = 0;
  logic print_key = 0, print_done = 0, tr, rl = 1, skip = 0;
  logic [15:0] division_size = 16'h000a;
  tare_perm_type tare_permission = tare_both;
  peak_mode_type peak_mode = peak_off;
  logic signed [23:0] gross_q, net_q, tare_q, peak_q, display_q;
  logic signed [31:0] accumulate_on_print_q;
  logic tare_refused_q, print_req_q, display_on_q, cutout_q;
  int n_errors = 0, check_count = 0, et = 0, cd[3] = '{2, 2, 2};
  int bd[9] = '{0, 2, 5, 10, 20, 50, 100, 200, 250};
  int unsigned seed = 52491;
  longint h[3][$];

  scale_weight_filter_peak_hold scale_weight_filter_peak_hold_inst (
    .sys_clk, .sys_rst, .reading_valid, .reading, .cfg_load, .avg_stage_one,
    .avg_stage_two, .avg_stage_three, .outlier_run_length, .cutout_band,
    .vibration_cancel, .tare_permission, .accumulate_on_print, .scale_visible,
    .peak_mode, .division_size, .standstill, .pushbutton_tare, .keyed_tare,
    .keyed_tare_value, .zero_key, .print_key, .print_done, .gross_q, .net_q,
    .tare_q, .tare_refused_q, .peak_q, .print_req_q, .accumulate_on_print_q, .display_q,
    .display_on_q, .cutout_q);
  adc_model adc_model_inst (.sys_clk, .sys_rst, .go, .dly, .value,
    .reading_valid, .reading);

  // Free-running 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  // Repeatable xorshift values in 0..1999
  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed % 2000);
  endfunction : xs

  // Expected output of the three cascaded rolling averages
  function automatic int filt(int x);
    longint s;
    for (int i = 0; i < 3; i++)
    begin
      if (rl)
        h[i] = {};
      h[i].push_front(x);
      while (h[i].size() < (1 << cd[i]))
        h[i].push_front(x);
      if (h[i].size() > (1 << cd[i]))
        void'(h[i].pop_back());
      s = 0;
      for (int j = 0; j < h[i].size(); j++)
        s += h[i][j];
      x = int'(s >>> cd[i]);
    end
    return x;
  endfunction : filt

  task automatic ck(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : ck

  task automatic load();
    cfg_load = 1;
    @(posedge sys_clk) #1 cfg_load = 0;
    cd = '{avg_stage_one > 8 ? 8 : avg_stage_one,
      avg_stage_two > 8 ? 8 : avg_stage_two,
      avg_stage_three > 8 ? 8 : avg_stage_three};
    rl = 1;
  endtask : load

  // Key pulse; notes a refusal seen in either of the next two cycles
  task automatic pulse(ref logic s);
    s = 1;
    @(posedge sys_clk) #1 s = 0;
    tr = tare_refused_q;
    @(posedge sys_clk) #1 tr = tr | tare_refused_q;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : pulse

  // One reading through the model; cutout and filtered weight checked
  task automatic rd(input int v, input logic xc);
    logic c;
    value = 24'(v);
    dly = 4'(xs() % 4);
    go = 1;
    @(posedge sys_clk) #1 go = 0;
    for (int k = 0; k < 20 && !reading_valid; k++)
      @(posedge sys_clk) #1;
    @(posedge sys_clk) #1 c = cutout_q;
    @(posedge sys_clk) #1 c = c | cutout_q;
    ck("cutout", xc, c);
    repeat (4) @(posedge sys_clk);
    #1;
    rl = rl | xc;
    if (!skip)
      ck("gross", filt(v), gross_q);
    rl = 0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : rd

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // Stops a hang well past the expected run of about 2100 cycles
  initial
  begin
    #200000;
    n_errors++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    #1 sys_rst = 0;
    ck("display on", 1, display_on_q);
    ck("accumulate_on_print", 0, accumulate_on_print_q);
    for (int t = 0; t < 6; t++)
    begin
      if (t > 0)
        {avg_stage_one, avg_stage_two, avg_stage_three} =
          t == 1 ? 12'h000 : t == 2 ? 12'h888 : 12'(xs() * 7);
      if (t > 0)
        load();
      for (int k = 0; k < 6; k++)
        rd(xs() - 1000, 0);
    end
    {avg_stage_one, avg_stage_two, avg_stage_three} = 12'h000;
    division_size = 16'h0007;
    for (int b = 0; b < 10; b++)
    begin
      int lim, n;
      lim = b > 8 ? 0 : bd[b] * 7;
      n = 2 << (b % 3);
      cutout_band = 4'(b);
      outlier_run_length = 3'(b % 3);
      load();
      rd(0, 0);
      rd(lim, 0);
      for (int k = 1; k <= n; k++)
        rd(lim + k * (lim + 1), k == n && lim > 0);
    end
    {avg_stage_one, avg_stage_two, avg_stage_three} = 12'h333;
    cutout_band = 4'h8;
    outlier_run_length = 3'h0;
    load();
    rd(0, 0);
    rd(100000, 0);
    rd(100000, 1);
    rd(100000, 0);
    {avg_stage_one, avg_stage_two, avg_stage_three} = 12'h000;
    vibration_cancel = 1;
    load();
    skip = 1;
    for (int k = 0; k < 40; k++)
    begin
      rd(k % 32 < 16 ? 436 : 564, 0);
      if (k >= 16)
        ck("cancel", 500, gross_q);
    end
    skip = 0;
    vibration_cancel = 0;
    for (int i = 3; i >= 0; i--)
    begin
      tare_permission = tare_perm_type'(i);
      keyed_tare_value = 24'(111 * i);
      load();
      rd(400, 0);
      pulse(pushbutton_tare);
      ck("pb refused", i % 2, tr);
      if (i % 2 == 0)
        et = 400;
      ck("tare", et, tare_q);
      pulse(keyed_tare);
      ck("keyed refused", i == 1 || i == 2, tr);
      if (i != 1 && i != 2)
        et = 111 * i;
      ck("net", 400 - et, net_q);
    end
    rd(300, 0);
    pulse(print_key);
    ck("accumulate_on_print off", 0, accumulate_on_print_q);
    accumulate_on_print = 1;
    load();
    pulse(print_key);
    ck("accumulate_on_print on", 300, accumulate_on_print_q);
    peak_mode = peak_normal;
    load();
    rd(100, 0);
    rd(500, 0);
    rd(300, 0);
    ck("peak", 500, peak_q);
    ck("display", 500, display_q);
    pulse(zero_key);
    ck("peak loaded", 500, peak_q);
    rd(0, 0);
    pulse(zero_key);
    ck("peak zeroed", 0, peak_q);
    peak_mode = absolute_peak;
    load();
    rd(-700, 0);
    rd(300, 0);
    ck("peak abs", -700, peak_q);
    rd(0, 0);
    pulse(print_key);
    ck("peak printed", 0, peak_q);
    peak_mode = peak_auto;
    standstill = 1;
    load();
    rd(800, 0);
    rd(50, 0);
    ck("print req", 1, print_req_q);
    rd(0, 0);
    ck("print held", 1, print_req_q);
    pulse(print_done);
    ck("print req off", 0, print_req_q);
    ck("peak auto", 0, peak_q);
    ck("accumulate_on_print auto", 1100, accumulate_on_print_q);
    scale_visible = 0;
    load();
    repeat (4) @(posedge sys_clk);
    #1;
    ck("display on", 0, display_on_q);
    ck("display hidden", 0, display_q);
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
